// [tb/pdm_mode_monitor.sv]
// port checker for the power-down mode controller
`timescale 1ns/100ps
`default_nettype none
module pdm_mode_monitor (
  input wire logic              sys_clk,
  input wire logic              rst_n,
  input wire logic [15:0]       reg_addr,
  input wire logic              reg_rd,
  input wire logic              hw_standby_n,
  input wire logic [7:0]        reg_rdata,
  input wire pdm_pkg::pdm_ctl_t ctl
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_hw_held;
    !hw_standby_n ##1 !hw_standby_n;
  endsequence
  sequence s_first_rd;
    reg_rd && reg_addr == pdm_pkg::ADDR_STANDBY_CONTROL && hw_standby_n
      && $past(hw_standby_n) && !$past(hw_standby_n, 2);
  endsequence
  property p_hw_float; s_hw_held |-> ctl.io_hiz; endproperty
  a_hw_float: assert property (p_hw_float) else $error("pins not floating");
  property p_hw_reset; s_hw_held |-> ctl.wdt_rst && ctl.dtc_rst; endproperty
  a_hw_reset: assert property (p_hw_reset) else $error("units not reset");
  property p_irq; ctl.irq_run == !ctl.io_hiz; endproperty
  a_irq: assert property (p_irq) else $error("interrupt state wrong");
  property p_sw_clk; ctl.io_hold |-> !ctl.clk_run && !ctl.wdt_run && !ctl.wdt_rst; endproperty
  a_sw_clk: assert property (p_sw_clk) else $error("standby clock or watchdog");
  property p_periph; !ctl.clk_run |-> ctl.sci_rst && ctl.can_rst && ctl.adc_rst && ctl.pwm_rst;
  endproperty
  a_periph: assert property (p_periph) else $error("peripheral not reset");
  property p_medium; ctl.cpu_slow == ctl.can_reg_block; endproperty
  a_medium: assert property (p_medium) else $error("can access block wrong");
  property p_slow; ctl.cpu_slow |-> ctl.cpu_run && ctl.clk_run; endproperty
  a_slow: assert property (p_slow) else $error("slow cpu not running");
  property p_hw_init; s_first_rd |=> reg_rdata == 8'h08; endproperty
  a_hw_init: assert property (p_hw_init) else $error("standby not reloaded");
endmodule
bind pdm_power_down_mode_control pdm_mode_monitor u_mon (.sys_clk, .rst_n, .reg_addr,
  .reg_rd, .hw_standby_n, .reg_rdata, .ctl);
`default_nettype wire

// [tb/pdm_power_down_mode_control_bench.sv]
// self-checking bench for the power-down mode controller
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_total++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module pdm_power_down_mode_control_bench;
  logic              sys_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0;
  logic              sleep_exec = 0, wake_irq = 0, hw_standby_n = 1;
  logic [15:0]       reg_addr = 16'h0000;
  logic [7:0]        reg_wdata = 8'h00, reg_rdata;
  pdm_pkg::pdm_ctl_t ctl;
  int                err_total = 0, n_tests = 0, cyc = 0;
  pdm_power_down_mode_control u_dut (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .sleep_exec, .wake_irq, .hw_standby_n, .reg_rdata, .ctl);
  always #5 sys_clk = ~sys_clk;
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic chk_rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 `CHK(reg_rdata, e)
  endtask
  task automatic pulse(input bit go_sleep);
    @(posedge sys_clk);
    if (go_sleep) sleep_exec <= 1'b1; else wake_irq <= 1'b1;
    @(posedge sys_clk);
    sleep_exec <= 1'b0; wake_irq <= 1'b0;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin err_total++; finish_test(); end
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    chk_rd(pdm_pkg::ADDR_STANDBY_CONTROL, pdm_pkg::RST_STANDBY_CONTROL);
    chk_rd(pdm_pkg::ADDR_SYS_CLK_CONTROL, pdm_pkg::RST_SYS_CLK_CONTROL);
    chk_rd(pdm_pkg::ADDR_MSTOP_A, pdm_pkg::RST_MSTOP_A);
    chk_rd(pdm_pkg::ADDR_MSTOP_B, pdm_pkg::RST_MSTOP_B);
    chk_rd(pdm_pkg::ADDR_MSTOP_C, pdm_pkg::RST_MSTOP_C);
    chk_rd(pdm_pkg::ADDR_LOW_POWER_CTRL, pdm_pkg::RST_LOW_POWER_CTRL);
    chk_rd(16'hFDE5, 8'h00);
    `CHK(ctl.tpu_run, 1'b0)
    `CHK(ctl.sci_rst, 1'b1)
    wr(pdm_pkg::ADDR_STANDBY_CONTROL, 8'hFF);
    chk_rd(pdm_pkg::ADDR_STANDBY_CONTROL, 8'hF8);
    wr(pdm_pkg::ADDR_STANDBY_CONTROL, 8'h88);
    pulse(1'b1);
    `CHK(ctl.io_hold, 1'b1)
    `CHK(ctl.clk_run, 1'b0)
    chk_rd(pdm_pkg::ADDR_MODE_STATUS, 8'h03);
    chk_rd(pdm_pkg::ADDR_STANDBY_CONTROL, 8'h88);
    pulse(1'b0);
    `CHK(ctl.clk_run, 1'b1)
    chk_rd(pdm_pkg::ADDR_STANDBY_CONTROL, 8'h88);
    wr(pdm_pkg::ADDR_STANDBY_CONTROL, 8'h08);
    pulse(1'b1);
    chk_rd(pdm_pkg::ADDR_MODE_STATUS, 8'h02);
    `CHK(ctl.cpu_run, 1'b0)
    `CHK(ctl.dtc_run, 1'b1)
    pulse(1'b0);
    wr(pdm_pkg::ADDR_SYS_CLK_CONTROL, 8'h01);
    chk_rd(pdm_pkg::ADDR_MODE_STATUS, 8'h01);
    `CHK(ctl.can_reg_block, 1'b1)
    `CHK(ctl.cpu_slow, 1'b1)
    wr(pdm_pkg::ADDR_SYS_CLK_CONTROL, 8'h00);
    wr(pdm_pkg::ADDR_MSTOP_A, 8'h40);
    wr(pdm_pkg::ADDR_MSTOP_B, 8'h00);
    wr(pdm_pkg::ADDR_MSTOP_C, 8'h00);
    chk_rd(pdm_pkg::ADDR_MSTOP_A, 8'h40);
    `CHK(ctl.dtc_run, 1'b0)
    `CHK(ctl.dtc_rst, 1'b0)
    `CHK(ctl.tpu_run, 1'b1)
    `CHK(ctl.sci_rst, 1'b0)
    `CHK(ctl.ppg_run, 1'b1)
    `CHK(ctl.pwm_rst, 1'b0)
    `CHK(ctl.adc_rst, 1'b0)
    `CHK(ctl.can_rst, 1'b0)
    `CHK(ctl.wdt_run, 1'b1)
    wr(pdm_pkg::ADDR_STANDBY_CONTROL, 8'h80);
    @(posedge sys_clk);
    hw_standby_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1 `CHK(ctl.io_hiz, 1'b1)
    `CHK(ctl.wdt_rst, 1'b1)
    `CHK(ctl.irq_run, 1'b0)
    `CHK(ctl.dtc_rst, 1'b1)
    `CHK(ctl.adc_rst, 1'b1)
    @(posedge sys_clk);
    hw_standby_n <= 1'b1;
    chk_rd(pdm_pkg::ADDR_STANDBY_CONTROL, 8'h08);
    chk_rd(pdm_pkg::ADDR_MSTOP_A, pdm_pkg::RST_MSTOP_A);
    finish_test();
  end
endmodule
`default_nettype wire

// [verilog/pdm_pkg.sv]
// package for the power-down mode controller
package pdm_pkg;
  localparam logic [15:0] ADDR_STANDBY_CONTROL  = 16'hFDE4;
  localparam logic [15:0] ADDR_SYS_CLK_CONTROL  = 16'hFDE6;
  localparam logic [15:0] ADDR_MSTOP_A          = 16'hFDE8;
  localparam logic [15:0] ADDR_MSTOP_B          = 16'hFDE9;
  localparam logic [15:0] ADDR_MSTOP_C          = 16'hFDEA;
  localparam logic [15:0] ADDR_LOW_POWER_CTRL   = 16'hFDEC;
  localparam logic [15:0] ADDR_MODE_STATUS      = 16'hFDEE;

  localparam logic [7:0] RST_STANDBY_CONTROL = 8'h08;
  localparam logic [7:0] RST_SYS_CLK_CONTROL = 8'h00;
  localparam logic [7:0] RST_MSTOP_A         = 8'h3F;
  localparam logic [7:0] RST_MSTOP_B         = 8'hFF;
  localparam logic [7:0] RST_MSTOP_C         = 8'hFF;
  localparam logic [7:0] RST_LOW_POWER_CTRL  = 8'h00;
  localparam logic [7:0] STANDBY_WMASK       = 8'hF8;
  localparam logic [7:0] ZERO_BYTE           = 8'h00;

  localparam int SOFTWARE_STANDBY_SELECT_BIT  = 7;
  localparam int OPE_BIT   = 3;
  localparam int SCK_SEL_HI = 2;
  localparam int SCK_SEL_LO = 0;
  // module stop bit positions
  localparam int MSTP_DTC  = 6;
  localparam int MSTP_TPU  = 5;
  localparam int MSTP_PPG  = 3;
  localparam int MSTP_SCI  = 5;
  localparam int MSTP_PWM  = 1;
  localparam int MSTP_ADC  = 2;
  localparam int MSTP_CAN  = 3;

  typedef enum logic [2:0] {
    PDM_HIGH_SPEED   = 3'b000,
    PDM_MEDIUM_SPEED = 3'b001,
    PDM_SLEEP        = 3'b010,
    PDM_SW_STANDBY   = 3'b011,
    PDM_HW_STANDBY   = 3'b100
  } pdm_mode_t;

  typedef struct packed {
    logic clk_run;
    logic cpu_run;
    logic cpu_slow;
    logic irq_run;
    logic wdt_run;
    logic wdt_rst;
    logic dtc_run;
    logic dtc_rst;
    logic tpu_run;
    logic ppg_run;
    logic pbc_run;
    logic sci_rst;
    logic pwm_rst;
    logic adc_rst;
    logic can_rst;
    logic io_hold;
    logic io_hiz;
    logic can_reg_block;
  } pdm_ctl_t;
endpackage

// [verilog/pdm_power_down_mode_control.sv]
// power-down mode controller: registers, mode state and module controls
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// R1: reset and hardware standby load standby 0x08
// R2: software standby keeps standby register unchanged
// R3: standby select bit kept across interrupt wakeups
// R4: sleep picks mode from the standby select bit only
// R5: halted-retained modules stop but keep registers
// R6: halted-reset modules reinitialise registers and state
// R7: outside both standby modes, only modules with stop bit set halt
// R8: medium speed blocks can register access
// R9: clock runs except in both standby modes
// R10: cpu slow medium, halted sleep/standby, undefined hw
// R11: interrupts work except in hardware standby
// R12: serial pwm adc can reset when stopped/standby
// R13: dtc slow medium, retained stop, reset hardware
// R14: pins hold soft standby, float hardware; ram kept
// R15: watchdog retained soft standby, reset hardware
// R16: timer, bus unit, pattern retained when stopped
module pdm_power_down_mode_control (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic        sleep_exec,
  input  wire logic        wake_irq,
  input  wire logic        hw_standby_n,
  output logic [7:0]       reg_rdata,
  output pdm_pkg::pdm_ctl_t ctl
);

  typedef struct packed {
    logic [7:0]         sby;
    logic [7:0]         sck;
    logic [7:0]         mstp_a;
    logic [7:0]         mstp_b;
    logic [7:0]         mstp_c;
    logic [7:0]         lpwr;
    pdm_pkg::pdm_mode_t mode;
    logic [7:0]         rdata;
    pdm_pkg::pdm_ctl_t  ctl;
  } pdm_state_t;

  pdm_state_t state_reg;
  pdm_state_t state_next;

  function automatic logic addr_hit(input logic [15:0] a, input logic [15:0] ref_a);
    addr_hit = (a == ref_a);
  endfunction

  function automatic pdm_pkg::pdm_ctl_t mode_ctl(
    input pdm_pkg::pdm_mode_t m,
    input logic [7:0]         ma,
    input logic [7:0]         mb,
    input logic [7:0]         mc
  );
    pdm_pkg::pdm_ctl_t c;
    logic hw;
    logic sw;
    logic slp;
    c   = '0;
    hw  = (m == pdm_pkg::PDM_HW_STANDBY);
    sw  = (m == pdm_pkg::PDM_SW_STANDBY);
    slp = (m == pdm_pkg::PDM_SLEEP);
    c.clk_run  = !(hw || sw);                                         // R9
    c.cpu_run  = !(hw || sw || slp);                                  // R10
    c.cpu_slow = (m == pdm_pkg::PDM_MEDIUM_SPEED);                    // R10
    c.irq_run  = !hw;                                                 // R11
    c.wdt_run  = !(hw || sw);                                         // R15
    c.wdt_rst  = hw;                                                  // R15
    c.dtc_run  = !(hw || sw || ma[pdm_pkg::MSTP_DTC]);                // R13 R7 R5
    c.dtc_rst  = hw;                                                  // R13 R6
    c.tpu_run  = !(hw || sw || ma[pdm_pkg::MSTP_TPU]);                // R16 R7 R5
    c.ppg_run  = !(hw || sw || ma[pdm_pkg::MSTP_PPG]);                // R16
    c.pbc_run  = !(hw || sw);                                         // R16
    c.sci_rst  = hw || sw || mb[pdm_pkg::MSTP_SCI];                   // R12 R6 R7
    c.pwm_rst  = hw || sw || mc[pdm_pkg::MSTP_PWM];                   // R12
    c.adc_rst  = hw || sw || mb[pdm_pkg::MSTP_ADC];                   // R12
    c.can_rst  = hw || sw || mc[pdm_pkg::MSTP_CAN];                   // R12
    c.io_hold  = sw;                                                  // R14
    c.io_hiz   = hw;                                                  // R14
    c.can_reg_block = (m == pdm_pkg::PDM_MEDIUM_SPEED);               // R8
    return c;
  endfunction

  always_comb begin
    state_next       = state_reg;
    state_next.rdata = pdm_pkg::ZERO_BYTE;
    if (!hw_standby_n) begin
      state_next.sby    = pdm_pkg::RST_STANDBY_CONTROL;               // R1
      state_next.sck    = pdm_pkg::RST_SYS_CLK_CONTROL;
      state_next.mstp_a = pdm_pkg::RST_MSTOP_A;
      state_next.mstp_b = pdm_pkg::RST_MSTOP_B;
      state_next.mstp_c = pdm_pkg::RST_MSTOP_C;
      state_next.lpwr   = pdm_pkg::RST_LOW_POWER_CTRL;
      state_next.mode   = pdm_pkg::PDM_HW_STANDBY;
    end else begin
      if (reg_wr && !state_reg.ctl.io_hiz) begin
        if (addr_hit(reg_addr, pdm_pkg::ADDR_STANDBY_CONTROL))
          state_next.sby = reg_wdata & pdm_pkg::STANDBY_WMASK;
        if (addr_hit(reg_addr, pdm_pkg::ADDR_SYS_CLK_CONTROL))
          state_next.sck = reg_wdata;
        if (addr_hit(reg_addr, pdm_pkg::ADDR_MSTOP_A))
          state_next.mstp_a = reg_wdata;
        if (addr_hit(reg_addr, pdm_pkg::ADDR_MSTOP_B))
          state_next.mstp_b = reg_wdata;
        if (addr_hit(reg_addr, pdm_pkg::ADDR_MSTOP_C))
          state_next.mstp_c = reg_wdata;
        if (addr_hit(reg_addr, pdm_pkg::ADDR_LOW_POWER_CTRL))
          state_next.lpwr = reg_wdata;
      end
      unique case (state_reg.mode)
        pdm_pkg::PDM_HIGH_SPEED, pdm_pkg::PDM_MEDIUM_SPEED: begin
          if (sleep_exec) begin
            if (state_reg.sby[pdm_pkg::SOFTWARE_STANDBY_SELECT_BIT])                     // R4
              state_next.mode = pdm_pkg::PDM_SW_STANDBY;              // R2
            else
              state_next.mode = pdm_pkg::PDM_SLEEP;
          end else if (state_reg.sck[pdm_pkg::SCK_SEL_HI:pdm_pkg::SCK_SEL_LO] != 3'h0) begin
            state_next.mode = pdm_pkg::PDM_MEDIUM_SPEED;
          end else begin
            state_next.mode = pdm_pkg::PDM_HIGH_SPEED;
          end
        end
        pdm_pkg::PDM_SLEEP, pdm_pkg::PDM_SW_STANDBY: begin
          if (wake_irq)
            state_next.mode = pdm_pkg::PDM_HIGH_SPEED;                // R3
        end
        pdm_pkg::PDM_HW_STANDBY: begin
          state_next.mode = pdm_pkg::PDM_HIGH_SPEED;
        end
        default: begin
          state_next.mode = pdm_pkg::PDM_HIGH_SPEED;
        end
      endcase
      if (reg_rd) begin
        if (addr_hit(reg_addr, pdm_pkg::ADDR_STANDBY_CONTROL))
          state_next.rdata = state_reg.sby;
        else if (addr_hit(reg_addr, pdm_pkg::ADDR_SYS_CLK_CONTROL))
          state_next.rdata = state_reg.sck;
        else if (addr_hit(reg_addr, pdm_pkg::ADDR_MSTOP_A))
          state_next.rdata = state_reg.mstp_a;
        else if (addr_hit(reg_addr, pdm_pkg::ADDR_MSTOP_B))
          state_next.rdata = state_reg.mstp_b;
        else if (addr_hit(reg_addr, pdm_pkg::ADDR_MSTOP_C))
          state_next.rdata = state_reg.mstp_c;
        else if (addr_hit(reg_addr, pdm_pkg::ADDR_LOW_POWER_CTRL))
          state_next.rdata = state_reg.lpwr;
        else if (addr_hit(reg_addr, pdm_pkg::ADDR_MODE_STATUS))
          state_next.rdata = {5'h0_0, state_reg.mode};
      end
    end
    state_next.ctl = mode_ctl(state_next.mode, state_next.mstp_a,
                              state_next.mstp_b, state_next.mstp_c);
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_reg.sby    <= pdm_pkg::RST_STANDBY_CONTROL;                // R1
      state_reg.sck    <= pdm_pkg::RST_SYS_CLK_CONTROL;
      state_reg.mstp_a <= pdm_pkg::RST_MSTOP_A;
      state_reg.mstp_b <= pdm_pkg::RST_MSTOP_B;
      state_reg.mstp_c <= pdm_pkg::RST_MSTOP_C;
      state_reg.lpwr   <= pdm_pkg::RST_LOW_POWER_CTRL;
      state_reg.mode   <= pdm_pkg::PDM_HIGH_SPEED;
      state_reg.rdata  <= pdm_pkg::ZERO_BYTE;
      state_reg.ctl    <= mode_ctl(pdm_pkg::PDM_HIGH_SPEED, pdm_pkg::RST_MSTOP_A,
                                   pdm_pkg::RST_MSTOP_B, pdm_pkg::RST_MSTOP_C);
    end else begin
      state_reg <= state_next;
    end
  end

  assign reg_rdata = state_reg.rdata;
  assign ctl       = state_reg.ctl;

endmodule
`default_nettype wire
